// File: rtl/lsd_pkg.sv
// Constants and state types of the serial display controller.
// Assumes a 25 MHz system clock and a host that drives the strobes.

package lsd_pkg;

	// ========================================================================
	// Clocking and sizes
	localparam int SYS_CLK_HZ = 25_000_000;
	localparam int XTAL_HZ    = 32_768;
	localparam int XTAL_DIV   = SYS_CLK_HZ / XTAL_HZ;
	localparam int PRE_BITS   = 10;
	localparam int DIV_BITS   = 15;
	localparam int RAM_WORDS  = 32;

	// ========================================================================
	// Serial framing
	localparam logic [2:0] ID_READ  = 3'h6;
	localparam logic [2:0] ID_WRITE = 3'h5;
	localparam logic [2:0] ID_CMD   = 3'h4;
	localparam logic [3:0] ID_LEN   = 4'h3;
	localparam logic [3:0] ADDR_LEN = 4'h6;
	localparam logic [3:0] NIB_LEN  = 4'h4;
	localparam logic [3:0] CMD_LEN  = 4'h9;

	// ========================================================================
	// Command codes, the eight bits ahead of the ignored ninth
	localparam logic [7:0] CMD_SYSTEM_OFF   = 8'h00;
	localparam logic [7:0] CMD_SYSTEM_ON    = 8'h01;
	localparam logic [7:0] CMD_BIAS_OFF     = 8'h02;
	localparam logic [7:0] CMD_BIAS_ON      = 8'h03;
	localparam logic [7:0] CMD_TB_OUT_OFF   = 8'h04;
	localparam logic [7:0] CMD_WD_FLAG_OFF  = 8'h05;
	localparam logic [7:0] CMD_TB_OUT_ON    = 8'h06;
	localparam logic [7:0] CMD_WD_FLAG_ON   = 8'h07;
	localparam logic [7:0] CMD_TONE_OFF     = 8'h08;
	localparam logic [7:0] CMD_TONE_ON      = 8'h09;
	localparam logic [7:0] CMD_TB_CLEAR     = 8'h0D;
	localparam logic [6:0] CMD_WD_CLEAR     = 7'h07;
	localparam logic [3:0] CMD_PANEL        = 4'h2;
	localparam logic [2:0] CMD_TONE_HIGH    = 3'h2;
	localparam logic [3:0] CMD_TONE_LOW     = 4'h6;
	localparam logic [2:0] CMD_ALERT        = 3'h4;
	localparam logic [2:0] CMD_RATE         = 3'h5;
	localparam logic [7:0] CMD_TEST         = 8'hE0;
	localparam logic [7:0] CMD_NORMAL       = 8'hE3;

	// ========================================================================
	// Divider taps and watchdog stage
	localparam logic [3:0] TAP_TONE_HIGH = 4'h2;
	localparam logic [3:0] TAP_TONE_LOW  = 4'h3;
	localparam logic [3:0] TAP_ONE_HZ    = 4'hE;
	localparam logic [1:0] WD_STAGE_LAST = 2'h3;

	// ========================================================================
	// Register map, byte addresses, and field positions
	localparam logic [3:0] REG_CTRL      = 4'h0;
	localparam logic [3:0] REG_STATUS    = 4'h4;
	localparam logic [3:0] REG_VIEW      = 4'h8;
	localparam int         CTRL_LINK_BIT = 0;
	localparam int         CTRL_DFLT_BIT = 1;
	localparam int         STAT_WDTO_BIT = 14;
	localparam int         STAT_SEL_BIT  = 15;
	localparam int         VIEW_ADDR_LSB = 8;

	// ========================================================================
	// Types
	typedef struct packed {
		logic       osc_on;
		logic       bias_on;
		logic       bias_third;
		logic [1:0] com_sel;
		logic       tone_on;
		logic       tone_low;
		logic       tb_out_en;
		logic       wd_flag_en;
		logic       alert_en;
		logic [2:0] rate;
		logic       test;
	} lsd_cfg_type;

	localparam lsd_cfg_type CFG_DEFAULT = '{rate: 3'h7, default: 1'b0};

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} lsd_sync_type;

	typedef struct packed {
		logic [PRE_BITS-1:0] pre;
		logic [DIV_BITS-1:0] div;
		logic                tb_prev;
		logic [1:0]          stage;
		logic                wd_to;
	} lsd_tmr_type;

	typedef enum logic [5:0] {
		ST_ID     = 6'h01,
		ST_ADDR   = 6'h02,
		ST_RDATA  = 6'h04,
		ST_WDATA  = 6'h08,
		ST_CMD    = 6'h10,
		ST_IGNORE = 6'h20
	} lsd_ser_state_type;

	typedef struct packed {
		lsd_ser_state_type          st;
		logic [3:0]                 bit_cnt;
		logic [8:0]                 shreg;
		logic                       is_read;
		logic [5:0]                 addr;
		logic [3:0]                 out_sh;
		logic [1:0]                 out_cnt;
		logic                       oe;
		logic                       dout;
		lsd_cfg_type                cfg;
		logic                       wr_prev;
		logic                       rd_prev;
		logic                       link_en;
		logic [4:0]                 view;
		logic                       ack;
		logic [31:0]                rdata;
		logic                       tb_clr;
		logic                       wd_clr;
		logic                       alert_n;
		logic                       tone_p;
		logic                       tone_n;
		logic [RAM_WORDS-1:0][3:0]  ram;
	} lsd_top_type;

endpackage

// File: rtl/lsd_sync.sv
// Three-stage input synchroniser with an agreement filter.
// Assumes the input is asynchronous to CLK_SYS.

`timescale 1ns/1ps

module lsd_sync #(
	parameter logic INIT = 1'b1
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Pin and clean level
	input  wire logic d,
	output logic      q
);

	// ========================================================================
	// State
	lsd_pkg::lsd_sync_type r_r;
	lsd_pkg::lsd_sync_type r_nxt;

	// The first stage feeds only the second, so metastability stays there.
	always_comb
	begin
		r_nxt    = r_r;
		r_nxt.s1 = d;
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		if (r_r.s2 == r_r.s3)
		begin
			r_nxt.q = r_r.s3;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			r_r <= '{INIT, INIT, INIT, INIT};
		else
			r_r <= r_nxt;
	end

	assign q = r_r.q;

endmodule

// File: rtl/lsd_timer.sv
// Crystal-rate prescaler, shared divider, watchdog stage and tone taps.
// Assumes command pulses last one CLK_SYS cycle.

`timescale 1ns/1ps

module lsd_timer #(
	parameter int XTAL_DIV = lsd_pkg::XTAL_DIV
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic       run,
	input  wire logic       tb_clear,
	input  wire logic       wd_clear,
	input  wire logic [2:0] rate,
	// Results
	output logic            tb_level,
	output logic            tone_high,
	output logic            tone_low,
	output logic            wd_timeout
);

	localparam logic [lsd_pkg::PRE_BITS-1:0] PRE_LAST =
		lsd_pkg::PRE_BITS'(XTAL_DIV - 1);

	if (XTAL_DIV < 2 || XTAL_DIV > 2 ** lsd_pkg::PRE_BITS)
		$error("lsd_timer: XTAL_DIV out of range");

	lsd_pkg::lsd_tmr_type r_r;
	lsd_pkg::lsd_tmr_type r_nxt;
	logic                 tick;
	logic                 sel;
	logic                 rise;

	always_comb
	begin
		r_nxt = r_r;
		tick  = 1'b0;
		if (!run)
			r_nxt.pre = '0;
		else if (r_r.pre == PRE_LAST)
		begin
			r_nxt.pre = '0;
			tick      = 1'b1;
		end
		else
			r_nxt.pre = r_r.pre + 1'b1;
		if (tb_clear)
			r_nxt.div = '0;
		else if (tick)
			r_nxt.div = r_r.div + 1'b1;
		sel           = r_r.div[lsd_pkg::TAP_ONE_HZ - {1'b0, rate}];
		rise          = sel & ~r_r.tb_prev;
		r_nxt.tb_prev = sel;
		// Four periods of the selected rate make one watchdog time-out.
		if (wd_clear)
			r_nxt.stage = '0;
		else if (rise)
			r_nxt.stage = r_r.stage + 1'b1;
		// A time-out in the clearing cycle still lands.
		r_nxt.wd_to = (rise && r_r.stage == lsd_pkg::WD_STAGE_LAST) ||
			(r_r.wd_to && !wd_clear);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			r_r <= '0;
		else
			r_r <= r_nxt;
	end

	assign tb_level   = r_r.tb_prev;
	assign tone_high  = r_r.div[lsd_pkg::TAP_TONE_HIGH];
	assign tone_low   = r_r.div[lsd_pkg::TAP_TONE_LOW];
	assign wd_timeout = r_r.wd_to;

endmodule

// File: rtl/lsd_top.sv
// Serial command and data interpreter of a 32x4 segment display driver,
// with a classic Wishbone slave for status, control and memory viewing.
// Assumes host strobes far slower than CLK_SYS; all four link pins are resynchronised.
//
// Operation
// - 110, six address bits, four bits returned.
// - 101, six address bits, four bits stored.
// - 101 also returns addressed nibble before writing.
// - 100 then back-to-back nine-bit commands.
// - Command 00 stops oscillator and bias; default.
// - Command 01 starts the oscillator.
// - Command 03 turns panel bias on.
// - Command 04 disables time base output.
// - Command 05 disables watchdog flag output.
// - Command 07 enables watchdog flag output.
// - Command 08 stops the tone; default.
// - Command 0D clears the time base count.
// - Command 0E or 0F clears the watchdog.
// - 010x gives high tone, 0110 low.
// - 101x-0nnn picks rate and watchdog time-out.
// - E0 enters test mode, E3 returns normal.
// - Command 02 turns panel bias off.
// - Select high aborts and clears the mode.
// - Bits are taken on write strobe rising.
// - Read bits leave on read strobe falling.
//
// Local design decisions: the address map and register access over Wishbone.

`timescale 1ns/1ps

module lsd_top #(
	parameter int XTAL_DIV = lsd_pkg::XTAL_DIV
) (
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	// Serial link from the host
	input  wire logic        SEL_N,
	input  wire logic        WR_N,
	input  wire logic        RD_N,
	input  wire logic        DATA_I,
	output logic             DATA_O,
	output logic             DATA_OE,
	// Alert and tone pins
	output logic             ALERT_N,
	output logic             TONE_P,
	output logic             TONE_N,
	// Panel configuration
	output logic             OSC_ON,
	output logic             BIAS_ON,
	output logic             BIAS_THIRD,
	output logic [1:0]       COM_SEL,
	output logic             TEST_MODE,
	// Wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic [31:0]      WB_DAT_O,
	output logic             WB_ACK_O
);

	// ========================================================================
	// Helpers
	function automatic logic [4:0] ram_idx(input logic [5:0] a);
		return a[4:0];
	endfunction

	// Applies one decoded command word to the configuration.
	function automatic lsd_pkg::lsd_cfg_type apply_cmd(
		input lsd_pkg::lsd_cfg_type c,
		input logic [7:0]           k
	);
		lsd_pkg::lsd_cfg_type o;
		o = c;
		case (k)
			lsd_pkg::CMD_SYSTEM_OFF:
			begin
				o.osc_on  = 1'b0;
				o.bias_on = 1'b0;
			end
			lsd_pkg::CMD_SYSTEM_ON:   o.osc_on     = 1'b1;
			lsd_pkg::CMD_BIAS_OFF:    o.bias_on    = 1'b0;
			lsd_pkg::CMD_BIAS_ON:     o.bias_on    = 1'b1;
			lsd_pkg::CMD_TB_OUT_OFF:  o.tb_out_en  = 1'b0;
			lsd_pkg::CMD_WD_FLAG_OFF: o.wd_flag_en = 1'b0;
			lsd_pkg::CMD_TB_OUT_ON:   o.tb_out_en  = 1'b1;
			lsd_pkg::CMD_WD_FLAG_ON:  o.wd_flag_en = 1'b1;
			lsd_pkg::CMD_TONE_OFF:    o.tone_on    = 1'b0;
			lsd_pkg::CMD_TONE_ON:     o.tone_on    = 1'b1;
			lsd_pkg::CMD_TEST:        o.test       = 1'b1;
			lsd_pkg::CMD_NORMAL:      o.test       = 1'b0;
			default:
			begin
			end
		endcase
		// A commons code of 11 is undefined and leaves the panel alone.
		if (k[7:4] == lsd_pkg::CMD_PANEL && k[3:2] != 2'h3)
		begin
			o.com_sel    = k[3:2];
			o.bias_third = k[0];
		end
		if (k[7:5] == lsd_pkg::CMD_TONE_HIGH)
			o.tone_low = 1'b0;
		if (k[7:4] == lsd_pkg::CMD_TONE_LOW)
			o.tone_low = 1'b1;
		if (k[7:5] == lsd_pkg::CMD_ALERT)
			o.alert_en = k[3];
		if (k[7:5] == lsd_pkg::CMD_RATE && !k[3])
			o.rate = k[2:0];
		return o;
	endfunction

	// ========================================================================
	// Pin synchronisers
	localparam logic [3:0] SYNC_INIT = 4'h7;

	logic [3:0] pin_raw;
	logic [3:0] pin_q;

	assign pin_raw = {DATA_I, RD_N, WR_N, SEL_N};

	for (genvar i = 0; i < 4; i++)
	begin : g_sync
		lsd_sync #(
			.INIT (SYNC_INIT[i])
		) u_sync (
			.clk   (CLK_SYS),
			.rst_n (RST_N),
			.d     (pin_raw[i]),
			.q     (pin_q[i])
		);
	end

	// ========================================================================
	// State and timer
	localparam lsd_pkg::lsd_top_type R_RESET = '{
		st:      lsd_pkg::ST_ID,
		cfg:     lsd_pkg::CFG_DEFAULT,
		link_en: 1'b1,
		wr_prev: 1'b1,
		rd_prev: 1'b1,
		alert_n: 1'b1,
		default: '0
	};

	lsd_pkg::lsd_top_type r_r;
	lsd_pkg::lsd_top_type r_nxt;

	logic tb_level;
	logic tone_high;
	logic tone_low;
	logic wd_timeout;

	lsd_timer #(
		.XTAL_DIV (XTAL_DIV)
	) u_timer (
		.clk        (CLK_SYS),
		.rst_n      (RST_N),
		.run        (r_r.cfg.osc_on),
		.tb_clear   (r_r.tb_clr),
		.wd_clear   (r_r.wd_clr),
		.rate       (r_r.cfg.rate),
		.tb_level   (tb_level),
		.tone_high  (tone_high),
		.tone_low   (tone_low),
		.wd_timeout (wd_timeout)
	);

	// ========================================================================
	// Next state
	logic       sel_hi;
	logic       wr_rise;
	logic       wr_fall;
	logic       rd_fall;
	logic       din;
	logic [8:0] msb_sh;
	logic [3:0] nib;
	logic [5:0] addr_inc;
	logic       wb_req;
	logic       tone_sel;

	always_comb
	begin
		r_nxt    = r_r;
		sel_hi   = pin_q[0];
		din      = pin_q[3];
		wr_rise  = pin_q[1] & ~r_r.wr_prev;
		wr_fall  = ~pin_q[1] & r_r.wr_prev;
		rd_fall  = ~pin_q[2] & r_r.rd_prev;
		msb_sh   = {r_r.shreg[7:0], din};
		nib      = {din, r_r.shreg[3:1]};
		addr_inc = r_r.addr + 6'h01;
		wb_req   = WB_CYC_I & WB_STB_I;
		tone_sel = r_r.cfg.tone_low ? tone_low : tone_high;

		r_nxt.wr_prev = pin_q[1];
		r_nxt.rd_prev = pin_q[2];
		r_nxt.tb_clr  = 1'b0;
		r_nxt.wd_clr  = 1'b0;

		// Deselect drops the mode; the next frame must open with an ID.
		if (sel_hi || !r_r.link_en)
		begin
			r_nxt.st      = lsd_pkg::ST_ID;
			r_nxt.bit_cnt = '0;
			r_nxt.shreg   = '0;
			r_nxt.oe      = 1'b0;
		end
		else
		begin
			case (r_r.st)
				lsd_pkg::ST_ID:
				begin
					if (wr_rise)
					begin
						r_nxt.shreg   = msb_sh;
						r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
						if (r_r.bit_cnt == lsd_pkg::ID_LEN - 4'h1)
						begin
							r_nxt.bit_cnt = '0;
							r_nxt.shreg   = '0;
							case (msb_sh[2:0])
								lsd_pkg::ID_READ:
								begin
									r_nxt.st      = lsd_pkg::ST_ADDR;
									r_nxt.is_read = 1'b1;
								end
								lsd_pkg::ID_WRITE:
								begin
									r_nxt.st      = lsd_pkg::ST_ADDR;
									r_nxt.is_read = 1'b0;
								end
								lsd_pkg::ID_CMD: r_nxt.st = lsd_pkg::ST_CMD;
								default:         r_nxt.st = lsd_pkg::ST_IGNORE;
							endcase
						end
					end
				end
				lsd_pkg::ST_ADDR:
				begin
					if (wr_rise)
					begin
						r_nxt.shreg   = msb_sh;
						r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
						if (r_r.bit_cnt == lsd_pkg::ADDR_LEN - 4'h1)
						begin
							r_nxt.bit_cnt = '0;
							r_nxt.shreg   = '0;
							r_nxt.addr    = msb_sh[5:0];
							r_nxt.out_sh  = r_r.ram[ram_idx(msb_sh[5:0])];
							r_nxt.out_cnt = '0;
							r_nxt.st      = r_r.is_read ? lsd_pkg::ST_RDATA :
								lsd_pkg::ST_WDATA;
						end
					end
				end
				lsd_pkg::ST_RDATA:
				begin
					if (rd_fall)
					begin
						r_nxt.oe      = 1'b1;
						r_nxt.dout    = r_r.out_sh[0];
						r_nxt.out_sh  = {1'b0, r_r.out_sh[3:1]};
						r_nxt.out_cnt = r_r.out_cnt + 2'h1;
						if (r_r.out_cnt == 2'h3)
						begin
							r_nxt.addr   = addr_inc;
							r_nxt.out_sh = r_r.ram[ram_idx(addr_inc)];
						end
					end
				end
				lsd_pkg::ST_WDATA:
				begin
					// The line is released on write strobe falling, before the bit is taken on its rising.
					if (wr_fall)
						r_nxt.oe = 1'b0;
					if (rd_fall)
					begin
						r_nxt.oe     = 1'b1;
						r_nxt.dout   = r_r.out_sh[0];
						r_nxt.out_sh = {1'b0, r_r.out_sh[3:1]};
					end
					if (wr_rise)
					begin
						r_nxt.shreg   = {5'h00, nib};
						r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
						if (r_r.bit_cnt == lsd_pkg::NIB_LEN - 4'h1)
						begin
							r_nxt.ram[ram_idx(r_r.addr)] = nib;
							r_nxt.bit_cnt = '0;
							r_nxt.shreg   = '0;
							r_nxt.addr    = addr_inc;
							r_nxt.out_sh  = r_r.ram[ram_idx(addr_inc)];
						end
					end
				end
				lsd_pkg::ST_CMD:
				begin
					if (wr_rise)
					begin
						r_nxt.shreg   = msb_sh;
						r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
						if (r_r.bit_cnt == lsd_pkg::CMD_LEN - 4'h1)
						begin
							r_nxt.bit_cnt = '0;
							r_nxt.shreg   = '0;
							r_nxt.cfg     = apply_cmd(r_r.cfg, msb_sh[8:1]);
							r_nxt.tb_clr  = msb_sh[8:1] ==
								lsd_pkg::CMD_TB_CLEAR;
							// Disabling the alert also drops a latched time-out.
							r_nxt.wd_clr  = msb_sh[8:2] ==
								lsd_pkg::CMD_WD_CLEAR ||
								(msb_sh[8:6] == lsd_pkg::CMD_ALERT &&
								!msb_sh[4]);
						end
					end
				end
				lsd_pkg::ST_IGNORE:
				begin
				end
				default: r_nxt.st = lsd_pkg::ST_ID;
			endcase
		end

		// Wishbone: ack one cycle after the request, writes on the acked edge.
		r_nxt.ack = wb_req & ~r_r.ack;
		if (wb_req && !r_r.ack)
		begin
			case (WB_ADR_I)
				lsd_pkg::REG_CTRL:
					r_nxt.rdata = {31'h0, r_r.link_en};
				lsd_pkg::REG_STATUS:
				begin
					r_nxt.rdata = {18'h0, r_r.cfg};
					r_nxt.rdata[lsd_pkg::STAT_WDTO_BIT] = wd_timeout;
					r_nxt.rdata[lsd_pkg::STAT_SEL_BIT]  = ~sel_hi;
				end
				lsd_pkg::REG_VIEW:
					r_nxt.rdata = {19'h0, r_r.view, 4'h0,
						r_r.ram[r_r.view]};
				default: r_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (wb_req && r_r.ack && WB_WE_I && WB_SEL_I[0])
		begin
			case (WB_ADR_I)
				lsd_pkg::REG_CTRL:
				begin
					r_nxt.link_en = WB_DAT_I[lsd_pkg::CTRL_LINK_BIT];
					if (WB_DAT_I[lsd_pkg::CTRL_DFLT_BIT])
						r_nxt.cfg = lsd_pkg::CFG_DEFAULT;
				end
				lsd_pkg::REG_VIEW: r_nxt.view = WB_DAT_I[4:0];
				default:
				begin
				end
			endcase
		end

		// Alert pin: a latched watchdog time-out or a low time base level, each when enabled, with alert_en set.
		r_nxt.alert_n = ~(r_r.cfg.alert_en &&
			((r_r.cfg.wd_flag_en && wd_timeout) ||
			(r_r.cfg.tb_out_en && !tb_level)));
		r_nxt.tone_p  = r_r.cfg.tone_on & r_r.cfg.osc_on & tone_sel;
		r_nxt.tone_n  = r_r.cfg.tone_on & r_r.cfg.osc_on & ~tone_sel;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			r_r <= R_RESET;
		else
			r_r <= r_nxt;
	end

	// ========================================================================
	// Outputs
	assign DATA_O     = r_r.dout;
	assign DATA_OE    = r_r.oe;
	assign ALERT_N    = r_r.alert_n;
	assign TONE_P     = r_r.tone_p;
	assign TONE_N     = r_r.tone_n;
	assign OSC_ON     = r_r.cfg.osc_on;
	assign BIAS_ON    = r_r.cfg.bias_on;
	assign BIAS_THIRD = r_r.cfg.bias_third;
	assign COM_SEL    = r_r.cfg.com_sel;
	assign TEST_MODE  = r_r.cfg.test;
	assign WB_DAT_O   = r_r.rdata;
	assign WB_ACK_O   = r_r.ack;

endmodule

// File: sim/lsd_top_monitor.sv
// Concurrent checks on the ports of lsd_top, bound to every instance.
// Assumes the bench keeps link strobe levels at least four cycles long.

`timescale 1ns/1ps

module lsd_top_monitor #(
	parameter int XTAL_DIV = 2
) (
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	// Serial link
	input  wire logic        SEL_N,
	input  wire logic        RD_N,
	input  wire logic        DATA_OE,
	// Alert and configuration
	input  wire logic        ALERT_N,
	input  wire logic        OSC_ON,
	input  wire logic        BIAS_ON,
	input  wire logic        BIAS_THIRD,
	input  wire logic [1:0]  COM_SEL,
	input  wire logic        TEST_MODE,
	// Wishbone
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_ACK_O,
	input  wire logic [31:0] WB_DAT_O
);
	// ========================================================================
	// Assertions
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	chk_ack_after_req: assert property
		(WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack missing one cycle after request");
	chk_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	chk_ack_has_req: assert property
		(WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
		else $error("ack without request");
	chk_rdata_hold: assert property (!WB_ACK_O |-> $stable(WB_DAT_O))
		else $error("read data moved without ack");
	chk_oe_release: assert property (SEL_N [*8] |-> !DATA_OE)
		else $error("data line driven while deselected");
	chk_oe_after_rd: assert property ($rose(DATA_OE) |-> !$past(RD_N, 3))
		else $error("data driven without read strobe");
	chk_cfg_by_link: assert property
		($changed({OSC_ON, BIAS_ON, BIAS_THIRD, COM_SEL, TEST_MODE})
		|-> !$past(SEL_N, 2) || $past(WB_CYC_I, 2))
		else $error("config changed outside a frame");
	chk_alert_hold: assert property ($fell(ALERT_N) |=> (!ALERT_N) [*8])
		else $error("alert released too soon");
endmodule

bind lsd_top lsd_top_monitor #(.XTAL_DIV(XTAL_DIV)) i_lsd_top_monitor (
	.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SEL_N(SEL_N), .RD_N(RD_N),
	.DATA_OE(DATA_OE), .ALERT_N(ALERT_N), .OSC_ON(OSC_ON),
	.BIAS_ON(BIAS_ON), .BIAS_THIRD(BIAS_THIRD), .COM_SEL(COM_SEL),
	.TEST_MODE(TEST_MODE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O));

// File: sim/lsd_host.sv
// Host controller model driving the serial select, strobes and data line.
// Assumes its tasks are called right after a rising edge of clk.

`timescale 1ns/1ps

module lsd_host (
	// Clock
	input  wire logic clk,
	// Link pins
	output logic      sel_n,
	output logic      wr_n,
	output logic      rd_n,
	output logic      line_oe,
	output logic      line_o,
	input  wire logic line_in
);
	logic line_d;
	logic junk;
	int   lo;

	// ========================================================================
	// Released line shows a toggling pattern, so no stale bit can pass.
	initial
	begin
		sel_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		line_oe = 1'b0;
		line_d = 1'b0;
		junk = 1'b0;
		lo = 4;
	end
	always @(posedge clk) junk <= ~junk;
	assign line_o = line_oe ? line_d : junk;

	task wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask

	task frame_on;
		sel_n <= 1'b0;
		wait_n(4);
	endtask

	task frame_off;
		wait_n(4);
		sel_n <= 1'b1;
		wait_n(8);
	endtask

	task send(input logic [8:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			wr_n <= 1'b0;
			line_d <= v[i];
			line_oe <= 1'b1;
			wait_n(lo);
			wr_n <= 1'b1;
			wait_n(4);
		end
	endtask

	task sendn(input logic [3:0] v);
		send({5'h00, v[0], v[1], v[2], v[3]}, 4);
	endtask

	task recv(input int n, output logic [7:0] v);
		v = 8'h00;
		for (int i = 0; i < n; i++)
		begin
			line_oe <= 1'b0;
			rd_n <= 1'b0;
			wait_n(4);
			rd_n <= 1'b1;
			wait_n(4);
			v[i] = line_in;
		end
	endtask
endmodule

// File: sim/lsd_top_tb.sv
// Self-checking bench for lsd_top with a host model on the serial link.
// Assumes a shortened crystal divider so the watchdog expires quickly.

`timescale 1ns/1ps

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end

module lsd_top_tb;
	logic        clk;
	logic        rst_n;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [3:0]  adr;
	logic [3:0]  bsel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	wire  [31:0] dat_o;
	wire         ack, sel_n, wr_n, rd_n, h_oe, h_line, data_o, data_oe;
	wire         alert_n, osc_on, bias_on, bias_third, test_mode;
	wire         tone_p, tone_n;
	wire  [1:0]  com_sel;
	wire         data_i = data_oe ? data_o : h_line;
	int          fail_count;
	int          checks_done;
	logic [7:0]  cmds [21] = '{8'h01, 8'h03, 8'h02, 8'h03, 8'h29, 8'h06,
		8'h04, 8'h07, 8'h05, 8'h09, 8'h60, 8'h40, 8'h08, 8'h88, 8'h80,
		8'hA3, 8'hA7, 8'h0D, 8'hE0, 8'hE3, 8'h00};
	logic [15:0] exps [21] = '{16'h200E, 16'h300E, 16'h200E, 16'h300E,
		16'h3C0E, 16'h3C4E, 16'h3C0E, 16'h3C2E, 16'h3C0E, 16'h3D0E,
		16'h3D8E, 16'h3D0E, 16'h3C0E, 16'h3C1E, 16'h3C0E, 16'h3C06,
		16'h3C0E, 16'h3C0E, 16'h3C0F, 16'h3C0E, 16'h0C0E};

	lsd_top #(.XTAL_DIV(2)) i_lsd_top (
		.CLK_SYS(clk), .RST_N(rst_n), .SEL_N(sel_n), .WR_N(wr_n),
		.RD_N(rd_n), .DATA_I(data_i), .DATA_O(data_o), .DATA_OE(data_oe),
		.ALERT_N(alert_n), .TONE_P(tone_p), .TONE_N(tone_n),
		.OSC_ON(osc_on),
		.BIAS_ON(bias_on), .BIAS_THIRD(bias_third), .COM_SEL(com_sel),
		.TEST_MODE(test_mode), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(bsel), .WB_DAT_I(wdat),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack));

	lsd_host i_lsd_host (.clk(clk), .sel_n(sel_n), .wr_n(wr_n),
		.rd_n(rd_n), .line_oe(h_oe), .line_o(h_line), .line_in(data_i));

	// ========================================================================
	// Clock, bus and frame helpers
	always #20 clk = ~clk;

	task final_report;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				fail_count++;
				final_report;
			end
			@(posedge clk);
		end
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task cmd(input logic [7:0] c);
		i_lsd_host.frame_on;
		i_lsd_host.send(9'h004, 3);
		i_lsd_host.send({c, 1'b0}, 9);
		i_lsd_host.frame_off;
	endtask

	// ========================================================================
	// Scenarios
	task t_reset;
		`CHK({osc_on, bias_on, bias_third, com_sel, test_mode, alert_n,
			data_oe}, 8'h02)
		wb(1'b0, 4'h4, 32'h0);
		`CHK(rdat, 32'h0000000E)
		wb(1'b0, 4'hC, 32'h0);
		`CHK(rdat, 32'h0)
		$display("reset test done");
	endtask

	task t_table;
		for (int i = 0; i < 21; i++)
		begin
			cmd(cmds[i]);
			wb(1'b0, 4'h4, 32'h0);
			`CHK(rdat, {16'h0, exps[i]})
			`CHK(tone_p ^ tone_n, exps[i][8])
		end
		// Control word: keep the link alive and restore power-on settings.
		wb(1'b1, 4'h0, 32'h3);
		wb(1'b0, 4'h4, 32'h0);
		`CHK(rdat, 32'h0000000E)
		wb(1'b0, 4'h0, 32'h0);
		`CHK(rdat, 32'h00000001)
		$display("command table test done");
	endtask

	task t_link;
		i_lsd_host.frame_on;
		i_lsd_host.send(9'h004, 3);
		i_lsd_host.send(9'h002, 9);
		i_lsd_host.send(9'h006, 9);
		i_lsd_host.frame_off;
		`CHK({osc_on, bias_on}, 2'b11)
		i_lsd_host.frame_on;
		i_lsd_host.send(9'h000, 9);
		i_lsd_host.frame_off;
		`CHK({osc_on, bias_on}, 2'b11)
		$display("back to back and abort test done");
	endtask

	task t_mem;
		logic [7:0] v;
		i_lsd_host.frame_on;
		i_lsd_host.send(9'h005, 3);
		i_lsd_host.send(9'h01F, 6);
		i_lsd_host.sendn(4'hA);
		i_lsd_host.sendn(4'h5);
		i_lsd_host.frame_off;
		i_lsd_host.frame_on;
		i_lsd_host.send(9'h006, 3);
		i_lsd_host.send(9'h01F, 6);
		i_lsd_host.recv(8, v);
		i_lsd_host.frame_off;
		`CHK(v, 8'h5A)
		wb(1'b1, 4'h8, 32'h0);
		wb(1'b0, 4'h8, 32'h0);
		`CHK(rdat, 32'h00000005)
		i_lsd_host.frame_on;
		i_lsd_host.send(9'h005, 3);
		i_lsd_host.send(9'h01F, 6);
		i_lsd_host.recv(4, v);
		i_lsd_host.lo = 8;
		i_lsd_host.sendn(4'hC);
		i_lsd_host.lo = 4;
		i_lsd_host.frame_off;
		`CHK(v, 8'h0A)
		i_lsd_host.frame_on;
		i_lsd_host.send(9'h006, 3);
		i_lsd_host.send(9'h01F, 6);
		i_lsd_host.recv(4, v);
		i_lsd_host.frame_off;
		`CHK(v, 8'h0C)
		$display("memory test done");
	endtask

	task t_wd;
		cmd(8'h07);
		cmd(8'h88);
		for (int n = 0; n < 5000 && alert_n !== 1'b0; n++)
			@(posedge clk);
		`CHK(alert_n, 1'b0)
		i_lsd_host.wait_n(40);
		`CHK(alert_n, 1'b0)
		cmd(8'h0F);
		`CHK(alert_n, 1'b1)
		$display("watchdog test done");
	endtask

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		bsel = 4'hF;
		wdat = 32'h0;
		fail_count = 0;
		checks_done = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset;
		t_table;
		t_link;
		t_mem;
		t_wd;
		final_report;
	end
endmodule
